// ### rtl/nsr_top.sv
// note sequence recorder core: record, store and play back note words
//
// Overview of operation
// - pitch takes one of 63 codes; duration between triggers is kept per note
// - recording digitises the input pitch and stores it with an interval count
// - playback paces notes by stored duration, outputs pitch, issues own trigger
// - a note word is 14 bits: six pitch bits over eight duration bits
// - note memory holds 1008 bits, 72 words, arranged as three groups
// - partition selects 3x24, 48 plus 24, or a single 72-note sequence
// - adjustable tick times durations, tempo range one sixteenth to sixteen
// - selector passes input pitch when recording, device pitch when playing
// - first trigger clears counters, sets address; 14 shift clocks store each word
// - terminate closes the last note, writes a zero marker unless the group is full, then starts playback
// - playback loads pitch and complemented duration, counts up to all ones
// - playback restarts on zero duration or group maximum, until terminate or record
`timescale 1ns/1ps
`include "nsr_params.svh"
module nsr_top #(
   parameter int TICK_CYC = `NSR_TICK_CYC,
   parameter int FIFO_DEPTH = 8
) (
   // clock and reset
   input wire logic i_clock,
   input wire logic i_rst_n,
   // apb slave
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [7:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   // synthesizer side
   input wire logic i_trigger_input,
   input wire logic i_pitch_cmp_hi,
   output logic [5:0] o_dac_code,
   output logic o_pitch_src_dev,
   output logic o_trigger
);
   localparam int TICK_MIN = TICK_CYC / `NSR_TEMPO_SPAN;
   localparam int TICK_MAX = TICK_CYC * `NSR_TEMPO_SPAN;

   if (TICK_CYC < `NSR_TEMPO_SPAN || TICK_CYC > 32'h07ffffff || FIFO_DEPTH < 2
       || `NSR_RAMP_CYC < 4 || `NSR_TRIG_CYC > 255) begin : g_chk
      $error("nsr_top: tick, fifo or timing constants out of range");
   end

   // memory arrangement per partition setting
   function automatic nsr_pkg::nsr_grp_s grp_map(input logic [1:0] part,
                                                 input logic [1:0] grp);
      nsr_pkg::nsr_grp_s g;
      logic [1:0] gi;
      gi = (grp > 2'h2) ? 2'h2 : grp;
      case (part)
         2'h0: begin
            g.base = 7'(gi) * `NSR_GRP_NOTES;
            g.max = `NSR_GRP_NOTES;
         end
         2'h1: begin
            g.base = (gi == 2'h0) ? 7'h00 : `NSR_GRP_NOTES + `NSR_GRP_NOTES;
            g.max = (gi == 2'h0) ? `NSR_GRP_NOTES + `NSR_GRP_NOTES : `NSR_GRP_NOTES;
         end
         default: begin
            g.base = 7'h00;
            g.max = `NSR_MEM_NOTES;
         end
      endcase
      return g;
   endfunction : grp_map

   function automatic logic [9:0] word_addr(input logic [6:0] w);
      return 10'(w) * 10'(`NSR_WORD_W);
   endfunction : word_addr

   function automatic logic [31:0] clamp_tick(input logic [31:0] v);
      if (v < 32'(TICK_MIN)) begin
         return 32'(TICK_MIN);
      end else if (v > 32'(TICK_MAX)) begin
         return 32'(TICK_MAX);
      end
      return v;
   endfunction : clamp_tick

   function automatic nsr_pkg::nsr_core_s play_from(input nsr_pkg::nsr_core_s s,
                                                    input logic [9:0] a);
      nsr_pkg::nsr_core_s r;
      r = s;
      r.state = nsr_pkg::ST_PLAY_FETCH;
      r.rd_addr = a;
      r.rd_bit = 4'h0;
      r.notes = 7'h00;
      return r;
   endfunction : play_from

   nsr_pkg::nsr_core_s q_ff;
   nsr_pkg::nsr_core_s nxt_q;
   nsr_pkg::nsr_grp_s g;
   logic [9:0] base_a;
   logic wr_apb;
   logic cmd_rec;
   logic cmd_play;
   logic cmd_term;
   logic tick;
   logic trg_rise;
   logic fifo_in_valid;
   logic fifo_in_ready;
   logic fifo_out_valid;
   logic [13:0] fifo_in_data;
   logic [13:0] fifo_out_data;
   logic [13:0] fetched;
   logic fetch_done;
   logic room;

   assign g = grp_map(q_ff.part, q_ff.grp);
   assign base_a = word_addr(g.base);
   assign wr_apb = i_psel & i_penable & q_ff.pready & i_pwrite;
   assign cmd_rec = wr_apb & (i_paddr == `NSR_ADDR_CMD) & i_pwdata[`NSR_CMD_REC];
   assign cmd_play = wr_apb & (i_paddr == `NSR_ADDR_CMD) & i_pwdata[`NSR_CMD_PLAY];
   assign cmd_term = wr_apb & (i_paddr == `NSR_ADDR_CMD) & i_pwdata[`NSR_CMD_TERM];
   assign tick = q_ff.tick_cnt >= q_ff.period - 32'h1;
   assign trg_rise = ~q_ff.trg_lvl & q_ff.trg_s[1] & q_ff.trg_s[2];
   assign room = q_ff.notes < g.max;
   assign fifo_in_valid = (q_ff.state == nsr_pkg::ST_REC_PUSH)
                          | (q_ff.state == nsr_pkg::ST_REC_ZERO);
   assign fifo_in_data = (q_ff.state == nsr_pkg::ST_REC_ZERO) ? 14'h0000 : q_ff.note_word;
   assign fetched = {q_ff.mem[q_ff.rd_addr], q_ff.rd_sh[13:1]};
   assign fetch_done = (q_ff.state == nsr_pkg::ST_PLAY_FETCH) && (q_ff.rd_bit == 4'hd);

   nsr_fifo #(
      .WIDTH(`NSR_WORD_W),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .i_clock(i_clock),
      .i_rst_n(i_rst_n),
      .i_in_valid(fifo_in_valid),
      .i_in_data(fifo_in_data),
      .o_in_ready(fifo_in_ready),
      .o_out_valid(fifo_out_valid),
      .o_out_data(fifo_out_data),
      .i_out_ready(~q_ff.wr_busy)
   );

   always_comb begin
      nxt_q = q_ff;
      // pin synchronisers: a change counts once stages two and three agree
      nxt_q.trg_s = {q_ff.trg_s[1:0], i_trigger_input};
      nxt_q.cmp_s = {q_ff.cmp_s[1:0], i_pitch_cmp_hi};
      if (q_ff.trg_s[1] == q_ff.trg_s[2]) begin
         nxt_q.trg_lvl = q_ff.trg_s[2];
      end
      if (q_ff.cmp_s[1] == q_ff.cmp_s[2]) begin
         nxt_q.cmp_lvl = q_ff.cmp_s[2];
      end
      // apb: one wait state, read data loaded with pready
      nxt_q.pready = i_psel & i_penable & ~q_ff.pready;
      nxt_q.pslverr = 1'b0;
      nxt_q.prdata = 32'h0;
      if (nxt_q.pready) begin
         case (i_paddr)
            `NSR_ADDR_CTRL: nxt_q.prdata = {28'h0, q_ff.grp, q_ff.part};
            `NSR_ADDR_CMD: nxt_q.prdata = 32'h0;
            `NSR_ADDR_TICK: nxt_q.prdata = q_ff.period;
            `NSR_ADDR_STAT: begin
               nxt_q.prdata = {10'h0, q_ff.dac, q_ff.wr_busy, q_ff.notes, q_ff.state};
            end
            default: nxt_q.pslverr = 1'b1;
         endcase
      end
      if (wr_apb && i_paddr == `NSR_ADDR_CTRL) begin
         nxt_q.part = i_pwdata[`NSR_CTRL_PART_LSB +: 2];
         nxt_q.grp = i_pwdata[`NSR_CTRL_GRP_LSB +: 2];
      end
      if (wr_apb && i_paddr == `NSR_ADDR_TICK) begin
         nxt_q.period = clamp_tick(i_pwdata);
      end
      nxt_q.tick_cnt = tick ? 32'h0 : q_ff.tick_cnt + 32'h1;
      if (q_ff.trig_left != 8'h00) begin
         nxt_q.trig_left = q_ff.trig_left - 8'h01;
      end
      // memory writer: 14 shift clocks per word, address steps by one each
      if (q_ff.wr_busy) begin
         nxt_q.mem[q_ff.wr_addr] = q_ff.wr_sh[0];
         nxt_q.wr_sh = {1'b0, q_ff.wr_sh[13:1]};
         nxt_q.wr_addr = q_ff.wr_addr + 10'h001;
         nxt_q.wr_bit = q_ff.wr_bit + 4'h1;
         if (q_ff.wr_bit == 4'hd) begin
            nxt_q.wr_busy = 1'b0;
         end
      end else if (fifo_out_valid) begin
         nxt_q.wr_sh = fifo_out_data;
         nxt_q.wr_busy = 1'b1;
         nxt_q.wr_bit = 4'h0;
      end
      case (q_ff.state)
         nsr_pkg::ST_IDLE: begin
            nxt_q.state = nsr_pkg::ST_IDLE;
         end
         nsr_pkg::ST_REC_WAIT: begin
            if (trg_rise && !q_ff.wr_busy && !fifo_out_valid) begin
               nxt_q.wr_addr = base_a;
               nxt_q.notes = 7'h00;
               nxt_q.ramp = 6'h00;
               nxt_q.dwell = 8'h00;
               nxt_q.pitch_got = 1'b0;
               nxt_q.dur = 8'h00;
               nxt_q.state = nsr_pkg::ST_REC_NOTE;
            end
         end
         nsr_pkg::ST_REC_NOTE: begin
            // ramp search: pitch taken where the ramp reaches the input
            // judged at the end of each step: a stale high from the last note must not count
            if (!q_ff.pitch_got) begin
               if (q_ff.dwell == 8'(`NSR_RAMP_CYC - 1)) begin
                  nxt_q.dwell = 8'h00;
                  if (q_ff.cmp_lvl || q_ff.ramp >= `NSR_MAX_PITCH) begin
                     nxt_q.pitch = q_ff.ramp;
                     nxt_q.pitch_got = 1'b1;
                  end else begin
                     nxt_q.ramp = q_ff.ramp + 6'h01;
                  end
               end else begin
                  nxt_q.dwell = q_ff.dwell + 8'h01;
               end
            end
            if (tick && q_ff.dur != 8'hff) begin
               nxt_q.dur = q_ff.dur + 8'h01;
            end
            // a zero count would read back as the end marker
            nxt_q.note_word = {nxt_q.pitch, (q_ff.dur == 8'h00) ? 8'h01 : q_ff.dur};
            if (cmd_term) begin
               nxt_q.term = 1'b1;
               nxt_q.state = room ? nsr_pkg::ST_REC_PUSH : nsr_pkg::ST_REC_DRAIN;
            end else if (trg_rise && room) begin
               nxt_q.term = 1'b0;
               nxt_q.state = nsr_pkg::ST_REC_PUSH;
            end
         end
         nsr_pkg::ST_REC_PUSH: begin
            if (fifo_in_ready) begin
               nxt_q.notes = q_ff.notes + 7'h01;
               nxt_q.ramp = 6'h00;
               nxt_q.dwell = 8'h00;
               nxt_q.pitch_got = 1'b0;
               nxt_q.dur = 8'h00;
               if (!q_ff.term) begin
                  nxt_q.state = nsr_pkg::ST_REC_NOTE;
               end else if (q_ff.notes + 7'h01 < g.max) begin
                  nxt_q.state = nsr_pkg::ST_REC_ZERO;
               end else begin
                  nxt_q.state = nsr_pkg::ST_REC_DRAIN;
               end
            end
         end
         nsr_pkg::ST_REC_ZERO: begin
            if (fifo_in_ready) begin
               nxt_q.state = nsr_pkg::ST_REC_DRAIN;
            end
         end
         nsr_pkg::ST_REC_DRAIN: begin
            if (!q_ff.wr_busy && !fifo_out_valid) begin
               nxt_q = play_from(nxt_q, base_a);
            end
         end
         nsr_pkg::ST_PLAY_FETCH: begin
            nxt_q.rd_sh = fetched;
            nxt_q.rd_addr = q_ff.rd_addr + 10'h001;
            nxt_q.rd_bit = q_ff.rd_bit + 4'h1;
            if (fetch_done) begin
               nxt_q.rd_bit = 4'h0;
               if (fetched[7:0] == 8'h00) begin
                  nxt_q = play_from(nxt_q, base_a);
               end else begin
                  nxt_q.dac = fetched[13:8];
                  nxt_q.dcnt = ~fetched[7:0];
                  nxt_q.trig_left = 8'(`NSR_TRIG_CYC);
                  nxt_q.state = nsr_pkg::ST_PLAY_NOTE;
               end
            end
         end
         nsr_pkg::ST_PLAY_NOTE: begin
            if (tick) begin
               if (q_ff.dcnt == 8'hff) begin
                  nxt_q.notes = q_ff.notes + 7'h01;
                  nxt_q.state = nsr_pkg::ST_PLAY_FETCH;
                  if (q_ff.notes + 7'h01 >= g.max) begin
                     nxt_q = play_from(nxt_q, base_a);
                  end
               end else begin
                  nxt_q.dcnt = q_ff.dcnt + 8'h01;
               end
            end
         end
         default: begin
            nxt_q.state = nsr_pkg::ST_IDLE;
         end
      endcase
      // panel requests override the sequence in progress
      if (cmd_rec) begin
         nxt_q.state = nsr_pkg::ST_REC_WAIT;
      end else if (cmd_play) begin
         nxt_q = play_from(nxt_q, base_a);
      end else if (cmd_term && (q_ff.state == nsr_pkg::ST_PLAY_FETCH
               || q_ff.state == nsr_pkg::ST_PLAY_NOTE || q_ff.state == nsr_pkg::ST_REC_WAIT)) begin
         nxt_q.state = nsr_pkg::ST_IDLE;
      end
      if (nxt_q.state == nsr_pkg::ST_REC_NOTE) begin
         nxt_q.dac = nxt_q.ramp;
      end
      nxt_q.dev_sel = (nxt_q.state == nsr_pkg::ST_PLAY_FETCH)
                      | (nxt_q.state == nsr_pkg::ST_PLAY_NOTE);
      nxt_q.trig = nxt_q.trig_left != 8'h00;
   end

   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         q_ff <= '0;
         q_ff.state <= nsr_pkg::ST_IDLE;
         q_ff.part <= `NSR_PART_RST;
         q_ff.grp <= `NSR_GRP_RST;
         q_ff.period <= 32'(TICK_CYC);
      end else begin
         q_ff <= nxt_q;
      end
   end

   assign o_prdata = q_ff.prdata;
   assign o_pready = q_ff.pready;
   assign o_pslverr = q_ff.pslverr;
   assign o_dac_code = q_ff.dac;
   assign o_pitch_src_dev = q_ff.dev_sel;
   assign o_trigger = q_ff.trig;

   default clocking cb @(posedge i_clock); endclocking
   default disable iff (!i_rst_n);

   AST_PITCH_RANGE: assert property (fifo_in_valid |-> fifo_in_data[13:8] <= `NSR_MAX_PITCH)
      else $error("pitch code above top level");
   AST_REC_COUNT: assert property (q_ff.state == nsr_pkg::ST_REC_PUSH |-> fifo_in_data[7:0] != 8'h00)
      else $error("recorded note lacks a duration count");
   AST_PLAY_TRIG: assert property (fetch_done && fetched[7:0] != 8'h00 && !wr_apb |=> o_trigger [*8])
      else $error("no trigger pulse at note start");
   AST_WORD_FIELDS: assert property (fetch_done && fetched[7:0] != 8'h00 && !wr_apb
                                     |=> o_dac_code == $past(fetched[13:8]))
      else $error("pitch field not taken from the upper six bits");
   AST_MEM_BOUND: assert property (q_ff.wr_addr <= 10'(`NSR_MEM_BITS)
                                   && q_ff.rd_addr <= 10'(`NSR_MEM_BITS))
      else $error("memory address beyond storage");
   AST_PARTITION: assert property (7'(g.base + g.max) <= `NSR_MEM_NOTES)
      else $error("group exceeds note memory");
   AST_TICK_SPAN: assert property (q_ff.period >= 32'(TICK_MIN) && q_ff.period <= 32'(TICK_MAX))
      else $error("tick period outside tempo span");
   AST_SELECTOR: assert property (q_ff.state == nsr_pkg::ST_REC_NOTE |-> !o_pitch_src_dev)
      else $error("device pitch routed out while recording");
   AST_BURST14: assert property ($rose(q_ff.wr_busy) && !cmd_rec
                                 |-> ##14 q_ff.wr_addr == $past(q_ff.wr_addr, 14) + 10'h00e)
      else $error("store burst did not advance by 14");
   AST_END_MARK: assert property (q_ff.state == nsr_pkg::ST_REC_ZERO && fifo_in_ready && !wr_apb
                                  |-> fifo_in_data == 14'h0000 ##1 q_ff.state == nsr_pkg::ST_REC_DRAIN)
      else $error("end marker not written as zero");
   AST_DUR_LOAD: assert property (fetch_done && fetched[7:0] != 8'h00 && !wr_apb
                                  |=> q_ff.dcnt == ~$past(fetched[7:0]))
      else $error("duration counter not loaded with complement");
   AST_RESTART: assert property (fetch_done && fetched[7:0] == 8'h00 && !wr_apb
                                 |=> q_ff.rd_addr == base_a && q_ff.notes == 7'h00)
      else $error("zero duration did not restart the group");
   AST_IDLE_RESET: assert property ($rose(i_rst_n) |-> q_ff.state == nsr_pkg::ST_IDLE && !o_trigger)
      else $error("not idle after reset");

   COV_NOTE_STORED: cover property (q_ff.state == nsr_pkg::ST_REC_PUSH && fifo_in_ready);
   COV_TERMINATE: cover property (q_ff.state == nsr_pkg::ST_REC_ZERO);
   COV_ZERO_RESTART: cover property (fetch_done && fetched[7:0] == 8'h00);
   COV_NOTE_END: cover property (q_ff.state == nsr_pkg::ST_PLAY_NOTE && tick && q_ff.dcnt == 8'hff);
endmodule : nsr_top

// ### rtl/nsr_params.svh
// constants of the note sequence recorder: offsets, fields, resets, timing
`ifndef NSR_PARAMS_SVH
`define NSR_PARAMS_SVH
`define NSR_ADDR_CTRL 8'h00
`define NSR_ADDR_CMD 8'h04
`define NSR_ADDR_TICK 8'h08
`define NSR_ADDR_STAT 8'h0c
`define NSR_CTRL_PART_LSB 0
`define NSR_CTRL_GRP_LSB 2
`define NSR_CMD_REC 0
`define NSR_CMD_PLAY 1
`define NSR_CMD_TERM 2
`define NSR_PART_RST 2'h0
`define NSR_GRP_RST 2'h0
`define NSR_WORD_W 14
`define NSR_MEM_BITS 1008
`define NSR_MAX_PITCH 6'h3e
`define NSR_GRP_NOTES 7'h18
`define NSR_MEM_NOTES 7'h48
`define NSR_CLK_HZ 200000000
`define NSR_CLK_NS 5
`define NSR_TICK_HZ 20
`define NSR_TICK_CYC (`NSR_CLK_HZ / `NSR_TICK_HZ)
`define NSR_TEMPO_SPAN 16
`define NSR_RAMP_NS 40
`define NSR_RAMP_CYC ((`NSR_RAMP_NS + `NSR_CLK_NS - 1) / `NSR_CLK_NS)
`define NSR_TRIG_NS 1000
`define NSR_TRIG_CYC ((`NSR_TRIG_NS + `NSR_CLK_NS - 1) / `NSR_CLK_NS)
`endif

// ### rtl/nsr_pkg.sv
// types of the note sequence recorder
`include "nsr_params.svh"
package nsr_pkg;
   typedef enum logic [7:0] {
      ST_IDLE = 8'h01,
      ST_REC_WAIT = 8'h02,
      ST_REC_NOTE = 8'h04,
      ST_REC_PUSH = 8'h08,
      ST_REC_ZERO = 8'h10,
      ST_REC_DRAIN = 8'h20,
      ST_PLAY_FETCH = 8'h40,
      ST_PLAY_NOTE = 8'h80
   } nsr_state_e;

   typedef struct packed {
      logic [6:0] base;
      logic [6:0] max;
   } nsr_grp_s;

   typedef struct packed {
      nsr_state_e state;
      logic [1:0] part;
      logic [1:0] grp;
      logic [31:0] period;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
      logic [2:0] trg_s;
      logic trg_lvl;
      logic [2:0] cmp_s;
      logic cmp_lvl;
      logic [31:0] tick_cnt;
      logic [5:0] ramp;
      logic [7:0] dwell;
      logic pitch_got;
      logic [5:0] pitch;
      logic [7:0] dur;
      logic term;
      logic [13:0] note_word;
      logic [6:0] notes;
      logic wr_busy;
      logic [3:0] wr_bit;
      logic [13:0] wr_sh;
      logic [9:0] wr_addr;
      logic [3:0] rd_bit;
      logic [13:0] rd_sh;
      logic [9:0] rd_addr;
      logic [7:0] dcnt;
      logic [5:0] dac;
      logic dev_sel;
      logic trig;
      logic [7:0] trig_left;
      logic [`NSR_MEM_BITS-1:0] mem;
   } nsr_core_s;
endpackage : nsr_pkg

// ### rtl/nsr_fifo.sv
// word fifo with valid and ready on both sides
`timescale 1ns/1ps
module nsr_fifo #(
   parameter int WIDTH = 14,
   parameter int DEPTH = 8
) (
   // clock and reset
   input wire logic i_clock,
   input wire logic i_rst_n,
   // filling side
   input wire logic i_in_valid,
   input wire logic [WIDTH-1:0] i_in_data,
   output logic o_in_ready,
   // draining side
   output logic o_out_valid,
   output logic [WIDTH-1:0] o_out_data,
   input wire logic i_out_ready
);
   localparam int AW = $clog2(DEPTH);

   if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_chk
      $error("nsr_fifo: depth must be a power of two, at least 2");
   end

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [AW:0] cnt;
   } nsr_fifo_s;

   nsr_fifo_s q_ff;
   nsr_fifo_s nxt_q;
   logic push;
   logic pop;

   assign o_in_ready = q_ff.cnt != (AW+1)'(DEPTH);
   assign o_out_valid = q_ff.cnt != '0;
   assign o_out_data = q_ff.mem[q_ff.rp];
   assign push = i_in_valid & o_in_ready;
   assign pop = o_out_valid & i_out_ready;

   always_comb begin
      nxt_q = q_ff;
      if (push) begin
         nxt_q.mem[q_ff.wp] = i_in_data;
         nxt_q.wp = q_ff.wp + 1'b1;
      end
      if (pop) begin
         nxt_q.rp = q_ff.rp + 1'b1;
      end
      nxt_q.cnt = q_ff.cnt + (AW+1)'(push) - (AW+1)'(pop);
   end

   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         q_ff <= '0;
      end else begin
         q_ff <= nxt_q;
      end
   end
endmodule : nsr_fifo

// ### sim/nsr_synth.sv
// keyboard and pitch comparator model of the synthesizer side
`timescale 1ns/1ps
module nsr_synth (
   // clock
   input wire logic i_clock,
   // device ramp code
   input wire logic [5:0] i_dac_code,
   // key state from the bench
   input wire logic [5:0] i_key_pitch,
   input wire logic i_press,
   // pins towards the device
   output logic o_trigger_input,
   output logic o_pitch_cmp_hi
);
   logic [4:0] hold_ff = 5'h00;
   // each key press gives a 16-cycle trigger pulse
   always_ff @(posedge i_clock) begin
      if (i_press) begin
         hold_ff <= 5'h10;
      end else if (hold_ff != 5'h00) begin
         hold_ff <= hold_ff - 5'h01;
      end
   end
   assign o_trigger_input = (hold_ff != 5'h00);
   // ramp at or above the held key voltage
   assign o_pitch_cmp_hi = (i_dac_code >= i_key_pitch);
endmodule : nsr_synth

// ### sim/tb_top.sv
// self-checking bench of the note sequence recorder
`timescale 1ns/1ps
`include "nsr_params.svh"
module tb_top;
   localparam int TCK = 32;
   logic clk, rst_n, psel, pen, pwr, press, pready, pslverr, trg_in, cmp, e, src, trg;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, q;
   logic [5:0] dac, key;
   logic [5:0] p [3];
   int g [3];
   int t [4];
   int seed, n_errors, samples_checked, cyc, i, w;

   nsr_top #(.TICK_CYC(TCK), .FIFO_DEPTH(8)) u_nsr_top (.i_clock(clk), .i_rst_n(rst_n),
      .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata),
      .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
      .i_trigger_input(trg_in), .i_pitch_cmp_hi(cmp), .o_dac_code(dac),
      .o_pitch_src_dev(src), .o_trigger(trg));
   nsr_synth u_nsr_synth (.i_clock(clk), .i_dac_code(dac), .i_key_pitch(key),
      .i_press(press), .o_trigger_input(trg_in), .o_pitch_cmp_hi(cmp));

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   always @(posedge clk) cyc <= cyc + 1;

   task automatic close_out();
      $display("checks %0d mismatches %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : close_out

   task automatic timeout();
      n_errors++;
      $display("CHECK FAILED wait expected answer seen timeout");
      close_out();
   endtask : timeout

   task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] y);
      samples_checked++;
      if (y !== x) begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", nm, x, y);
      end
   endtask : chk

   task automatic chk_near(input string nm, input int x, input int y, input int tol);
      samples_checked++;
      if (y < x - tol || y > x + tol) begin
         n_errors++;
         $display("CHECK FAILED %s expected %0d seen %0d", nm, x, y);
      end
   endtask : chk_near

   // one apb transfer; q and e hold the answer
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int k;
      @(posedge clk);
      psel <= 1'b1;
      pen <= 1'b0;
      pwr <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      pen <= 1'b1;
      k = 0;
      // answer is read where settled, then taken at the next rising edge
      do begin
         @(negedge clk);
         k++;
      end while (pready !== 1'b1 && k < 40);
      if (k >= 40) timeout();
      q = prdata;
      e = pslverr;
      @(posedge clk);
      psel <= 1'b0;
      pen <= 1'b0;
   endtask : apb

   task automatic wait_rise(output int at);
      int k;
      k = 0;
      while (trg !== 1'b1 && k < 20000) begin
         @(negedge clk);
         k++;
      end
      at = cyc;
      if (k >= 20000) timeout();
   endtask : wait_rise

   task automatic width(output int n);
      n = 0;
      while (trg === 1'b1 && n < 1000) begin
         @(negedge clk);
         n++;
      end
   endtask : width

   task automatic state(input logic [7:0] x);
      apb(1'b0, `NSR_ADDR_STAT, 32'h0);
      chk("state", {24'h0, x}, {24'h0, q[7:0]});
   endtask : state

   initial begin
      seed = 32'hc1f8;
      cyc = 0;
      n_errors = 0;
      samples_checked = 0;
      rst_n = 1'b0;
      {psel, pen, pwr, press} = 4'h0;
      paddr = 8'h00;
      pwdata = 32'h0;
      key = 6'h00;
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      state(8'h01);
      chk("source", 32'h0, {31'h0, src});
      apb(1'b0, `NSR_ADDR_TICK, 32'h0);
      chk("tick", TCK, q);
      apb(1'b1, `NSR_ADDR_TICK, 32'h1);
      apb(1'b0, `NSR_ADDR_TICK, 32'h0);
      chk("tick low", TCK / 16, q);
      apb(1'b1, `NSR_ADDR_TICK, 32'h10000);
      apb(1'b0, `NSR_ADDR_TICK, 32'h0);
      chk("tick high", TCK * 16, q);
      apb(1'b1, `NSR_ADDR_TICK, TCK);
      apb(1'b1, `NSR_ADDR_CTRL, 32'h9);
      apb(1'b0, `NSR_ADDR_CTRL, 32'h0);
      chk("ctrl", 32'h9, q);
      apb(1'b1, `NSR_ADDR_CTRL, 32'h0);
      apb(1'b0, 8'h40, 32'h0);
      chk("unmapped", 32'h1, {31'h0, e});
      $display("test registers done");
      apb(1'b1, `NSR_ADDR_CMD, 32'h1);
      state(8'h02);
      for (i = 0; i < 3; i++) begin
         p[i] = 6'($unsigned($random(seed)) % 63);
         g[i] = 600 + $unsigned($random(seed)) % 2000;
         key <= p[i];
         @(posedge clk);
         press <= 1'b1;
         @(posedge clk);
         press <= 1'b0;
         repeat (g[i]) @(posedge clk);
         chk("source", 32'h0, {31'h0, src});
      end
      apb(1'b1, `NSR_ADDR_CMD, 32'h4);
      $display("test record done");
      for (i = 0; i < 4; i++) begin
         wait_rise(t[i]);
         chk("source", 32'h1, {31'h0, src});
         width(w);
         chk("trigger width", `NSR_TRIG_CYC, w);
         chk("pitch", {26'h0, p[i % 3]}, {26'h0, dac});
         if (i > 0) chk_near("interval", g[i - 1], t[i] - t[i - 1], 100);
      end
      apb(1'b1, `NSR_ADDR_CMD, 32'h4);
      state(8'h01);
      $display("test playback done");
      apb(1'b1, `NSR_ADDR_TICK, 2 * TCK);
      apb(1'b1, `NSR_ADDR_CMD, 32'h2);
      wait_rise(t[0]);
      width(w);
      chk("pitch", {26'h0, p[0]}, {26'h0, dac});
      wait_rise(t[1]);
      chk_near("slow interval", 2 * g[0], t[1] - t[0], 200);
      apb(1'b1, `NSR_ADDR_CMD, 32'h1);
      state(8'h02);
      chk("source", 32'h0, {31'h0, src});
      apb(1'b1, `NSR_ADDR_CMD, 32'h4);
      state(8'h01);
      $display("test tempo done");
      close_out();
   end
endmodule : tb_top
